//--- logic/spbs_map.svh
// Constants for the pipelined burst SRAM: widths, depth, byte lanes,
// reset values and strap encodings.
// Assumes inclusion by bare name from files under logic/.
`ifndef SPBS_MAP_SVH
`define SPBS_MAP_SVH

// Array geometry
`define SPBS_ADDR_W 18
`define SPBS_DATA_W 16
`define SPBS_PAR_W 2
`define SPBS_WORD_W 18
`define SPBS_DEPTH 262144

// Byte lanes: lane i owns data [8*i +: 8] and parity bit i
`define SPBS_LANE_W 8
`define SPBS_LANES 2

// Burst counter
`define SPBS_BURST_W 2
`define SPBS_STEP_RST 2'h0

// Reset value of the captured address
`define SPBS_ADDR_RST 18'h00000

// Strap level that selects linear order
`define SPBS_STRAP_LINEAR 1'h0

`endif

//--- logic/spbs_pkg.sv
// Types shared by the pipelined burst SRAM files.
// Assumes spbs_map.svh is on the include path.
`include "spbs_map.svh"

package spbs_pkg;

  typedef logic [`SPBS_ADDR_W-1:0] spbs_addr_t;
  typedef logic [`SPBS_WORD_W-1:0] spbs_word_t;
  typedef logic [`SPBS_LANES-1:0] spbs_lane_t;
  typedef logic [`SPBS_BURST_W-1:0] spbs_step_t;

  typedef enum logic {
    SPBS_LINEAR,
    SPBS_INTERLEAVED
  } spbs_burst_e;

  typedef enum logic [1:0] {
    SPBS_DESEL,
    SPBS_SELECTED,
    SPBS_SLEEP
  } spbs_state_e;

endpackage : spbs_pkg

//--- logic/spbs_mem.sv
// Storage array of 256K words with per-lane write and combinational read.
// Assumes the caller registers the read address and the read data.
`timescale 1ns/1ps
`default_nettype none
`include "spbs_map.svh"

module spbs_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire spbs_pkg::spbs_addr_t wr_addr,
  input wire spbs_pkg::spbs_lane_t wr_lane,
  input wire spbs_pkg::spbs_word_t wr_word,
  // Read port
  input wire spbs_pkg::spbs_addr_t rd_addr,
  output logic [`SPBS_WORD_W-1:0] rd_word
);
  import spbs_pkg::*;

  spbs_word_t mem [0:`SPBS_DEPTH-1];

  // ==========================================================
  // Lane write, unselected lanes keep their content
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < `SPBS_LANES; i++) begin
        if (wr_lane[i]) begin
          mem[wr_addr][`SPBS_LANE_W*i +: `SPBS_LANE_W] <=
            wr_word[`SPBS_LANE_W*i +: `SPBS_LANE_W];
          mem[wr_addr][`SPBS_DATA_W+i] <= wr_word[`SPBS_DATA_W+i];
        end
      end
    end
  end

  // ==========================================================
  // Read
  assign rd_word = mem[rd_addr];

endmodule : spbs_mem
`default_nettype wire

//--- logic/spbs_top.sv
// Pipelined burst SRAM core: strobe decode, burst counter, writes,
// pipelined reads and data output drive control.
// Assumes all inputs but OUT_EN_N are synchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none
`include "spbs_map.svh"

module spbs_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Address and strobes
  input wire spbs_pkg::spbs_addr_t ADDR,
  input wire logic PROC_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  // Chip selects
  input wire logic CHIP_SEL_A_N,
  input wire logic CHIP_SEL_B,
  input wire logic CHIP_SEL_C_N,
  // Write controls
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_EN_N,
  input wire spbs_pkg::spbs_lane_t BYTE_SEL_N,
  // Mode, sleep and output enable
  input wire logic BURST_MODE_SEL,
  input wire logic SLEEP_REQ,
  input wire logic OUT_EN_N,
  // Data lines
  input wire logic [`SPBS_DATA_W-1:0] DATA_IN,
  output logic [`SPBS_DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  // Parity lines
  input wire logic [`SPBS_PAR_W-1:0] PARITY_IN,
  output logic [`SPBS_PAR_W-1:0] PARITY_OUT,
  output logic PARITY_OE
);
  import spbs_pkg::*;

  // ==========================================================
  // Helpers
  function automatic spbs_step_t burst_lo(spbs_burst_e m, spbs_step_t s,
                                          spbs_step_t n);
    if (m == SPBS_INTERLEAVED) begin
      burst_lo = s ^ n;
    end else begin
      burst_lo = s + n;
    end
  endfunction : burst_lo

  function automatic spbs_lane_t write_lanes(logic gw_n, logic bwe_n,
                                             spbs_lane_t bs_n);
    if (!gw_n) begin
      write_lanes = '1;
    end else if (!bwe_n) begin
      write_lanes = ~bs_n;
    end else begin
      write_lanes = '0;
    end
  endfunction : write_lanes

  // ==========================================================
  // State
  spbs_state_e state_q;
  spbs_burst_e mode_q;
  logic mode_taken_q;
  logic sleep_q;
  spbs_addr_t addr_q;
  spbs_step_t step_q;
  logic rd_pend_q;
  spbs_addr_t rd_addr_q;
  logic drive_q;
  logic [`SPBS_DATA_W-1:0] data_q;
  logic [`SPBS_PAR_W-1:0] par_q;

  // ==========================================================
  // Decode
  logic awake, proc_go, ctrl_go, strobe, cs_ok;
  logic begin_acc, desel, cont, wr_req, mem_we, rd_now;
  spbs_lane_t lanes;
  spbs_step_t eff_step;
  spbs_addr_t burst_addr, mem_wa;
  spbs_word_t rd_word;

  assign awake = (state_q != SPBS_SLEEP);
  assign proc_go = !PROC_ADDR_STROBE_N && !CHIP_SEL_A_N;
  assign ctrl_go = !CTRL_ADDR_STROBE_N && !proc_go;
  assign strobe = proc_go || ctrl_go;
  assign cs_ok = !CHIP_SEL_A_N && CHIP_SEL_B && !CHIP_SEL_C_N;
  assign begin_acc = awake && strobe && cs_ok;
  assign desel = awake && strobe && !cs_ok;
  assign cont = awake && !strobe && (state_q == SPBS_SELECTED);
  assign lanes = write_lanes(GLOBAL_WRITE_N, BYTE_WRITE_EN_N, BYTE_SEL_N);
  assign wr_req = |lanes;
  assign eff_step = step_q + {1'b0, !BURST_ADVANCE_N};
  assign burst_addr = {addr_q[`SPBS_ADDR_W-1:`SPBS_BURST_W],
                       burst_lo(mode_q, addr_q[`SPBS_BURST_W-1:0],
                                eff_step)};
  // Processor start never writes; its write lands on a later edge
  assign mem_we = (begin_acc && ctrl_go && wr_req)
                  || (cont && wr_req);
  assign mem_wa = begin_acc ? ADDR : burst_addr;
  assign rd_now = (begin_acc && (proc_go || !wr_req))
                  || (cont && !wr_req);

  spbs_mem u_mem (
    .clk(CLOCK),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_lane(lanes),
    .wr_word({PARITY_IN, DATA_IN}),
    .rd_addr(rd_addr_q),
    .rd_word(rd_word)
  );

  // ==========================================================
  // Strap capture after reset release
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode_q <= SPBS_INTERLEAVED;
      mode_taken_q <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_q <= (BURST_MODE_SEL == `SPBS_STRAP_LINEAR) ?
                SPBS_LINEAR : SPBS_INTERLEAVED;
      mode_taken_q <= 1'b1;
    end
  end

  // ==========================================================
  // Selection and sleep, two edges to enter or leave sleep
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= SLEEP_REQ;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= SPBS_DESEL;
    end else begin
      case (state_q)
        SPBS_DESEL: begin
          if (sleep_q) begin
            state_q <= SPBS_SLEEP;
          end else if (begin_acc) begin
            state_q <= SPBS_SELECTED;
          end
        end
        SPBS_SELECTED: begin
          if (sleep_q) begin
            state_q <= SPBS_SLEEP;
          end else if (desel) begin
            state_q <= SPBS_DESEL;
          end
        end
        SPBS_SLEEP: begin
          if (!sleep_q) begin
            state_q <= SPBS_DESEL;
          end
        end
        default: begin
          state_q <= SPBS_DESEL;
        end
      endcase
    end
  end

  // ==========================================================
  // Address register and burst counter
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      addr_q <= `SPBS_ADDR_RST;
      step_q <= `SPBS_STEP_RST;
    end else if (begin_acc) begin
      addr_q <= ADDR;
      step_q <= `SPBS_STEP_RST;
    end else if (cont) begin
      step_q <= eff_step;
    end
  end

  // ==========================================================
  // Read pipeline and output registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= `SPBS_ADDR_RST;
    end else begin
      rd_pend_q <= rd_now;
      rd_addr_q <= mem_wa;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      data_q <= '0;
      par_q <= '0;
    end else begin
      data_q <= rd_word[`SPBS_DATA_W-1:0];
      par_q <= rd_word[`SPBS_WORD_W-1:`SPBS_DATA_W];
    end
  end

  // Drive only after a read edge; a fresh select has no prior read
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      drive_q <= 1'b0;
    end else if (desel || mem_we || !awake || sleep_q) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= rd_pend_q;
    end
  end

  assign DATA_OUT = data_q;
  assign PARITY_OUT = par_q;
  // Output enable acts without the clock
  assign DATA_OE = drive_q && !OUT_EN_N;
  assign PARITY_OE = drive_q && !OUT_EN_N;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_desel_edge;
    desel;
  endsequence

  sequence s_fresh_read;
    begin_acc && rd_now && !rd_pend_q;
  endsequence

  chk_addr_capture: assert property (
    begin_acc |=> addr_q == $past(ADDR) && step_q == `SPBS_STEP_RST)
    else $error("address not captured on strobe");

  chk_proc_wins: assert property (
    !PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && cs_ok |-> !mem_we)
    else $error("controller strobe acted beside processor strobe");

  chk_sleep_quiet: assert property (
    !awake |-> !mem_we && !DATA_OE)
    else $error("activity while asleep");

  chk_oe_release: assert property (
    OUT_EN_N |-> !DATA_OE && !PARITY_OE)
    else $error("driving with output enable high");

  chk_read_pipe: assert property (
    rd_now ##1 (awake && !sleep_q && !desel && !mem_we) |=> drive_q
      && DATA_OUT == $past(rd_word[`SPBS_DATA_W-1:0]))
    else $error("read data not presented next edge");

  chk_emerge_mask: assert property (
    s_desel_edge ##1 s_fresh_read |=> !DATA_OE)
    else $error("outputs driven in first cycle after deselect");

  chk_desel_off: assert property (
    s_desel_edge |=> !drive_q)
    else $error("outputs kept after deselect");

  chk_write_off: assert property (
    mem_we |=> !DATA_OE)
    else $error("outputs driven after write cycle");

  chk_burst_step: assert property (
    cont && !BURST_ADVANCE_N |=> step_q == $past(step_q) + 2'h1)
    else $error("burst counter did not step");

  chk_burst_hold: assert property (
    cont && BURST_ADVANCE_N |=> $stable(step_q))
    else $error("burst counter moved while suspended");

  chk_ctrl_write: assert property (
    begin_acc && ctrl_go && !GLOBAL_WRITE_N |-> mem_we && mem_wa == ADDR)
    else $error("controller write not taken in its cycle");

  chk_proc_two: assert property (
    begin_acc && proc_go ##1 cont && !GLOBAL_WRITE_N |-> mem_we
      && mem_wa == burst_addr)
    else $error("processor write not taken on second edge");

endmodule : spbs_top
`default_nettype wire

//--- dv/spbs_host.sv
// Bus master model for the burst SRAM core: strobes, selects, writes.
// Assumes one task call at a time, made just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "spbs_map.svh"

module spbs_host (
  // Clock and device data
  input wire logic clk,
  input wire spbs_pkg::spbs_word_t dev_word,
  input wire logic dev_oe,
  // Bus controls
  output var spbs_pkg::spbs_addr_t addr,
  output logic proc_n,
  output logic ctrl_n,
  output logic adv_n,
  output logic sel_a_n,
  output logic sel_b,
  output logic sel_c_n,
  output logic gw_n,
  output logic bwe_n,
  output var spbs_pkg::spbs_lane_t bsel_n,
  output logic oe_n,
  output logic sleep,
  // Resolved data and parity lines
  output var spbs_pkg::spbs_word_t wire_word
);
  import spbs_pkg::*;
  spbs_word_t drv_word = '0;
  spbs_word_t last_q = '0;
  logic drv_on = 1'b0;

  // Released lines show the inverse of their last level
  assign wire_word = dev_oe ? dev_word : drv_on ? drv_word : ~last_q;
  always @(posedge clk) last_q <= wire_word;

  // ==========================================
  // Bus cycles
  task automatic set(input logic p, c, s, av, g, b, input spbs_lane_t bs,
                     input spbs_addr_t ad, input spbs_word_t w);
    proc_n = p;
    ctrl_n = c;
    adv_n = av;
    gw_n = g;
    bwe_n = b;
    bsel_n = bs;
    sel_a_n = !s;
    sel_b = s;
    sel_c_n = !s;
    addr = ad;
    drv_word = w;
    drv_on = !g || !b;
    oe_n = drv_on;
  endtask : set

  task automatic cyc(input logic p, c, s, av, g, b, input spbs_lane_t bs,
                     input spbs_addr_t ad, input spbs_word_t w);
    set(p, c, s, av, g, b, bs, ad, w);
    @(posedge clk);
    #1;
  endtask : cyc

  task automatic pins(input logic o, sl);
    oe_n = o;
    sleep = sl;
  endtask : pins

  initial begin
    set(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, '0, '0);
    sleep = 1'b0;
  end
endmodule : spbs_host
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the pipelined burst SRAM core.
// Assumes spbs_top and the bus master model spbs_host.
`timescale 1ns/1ps
`default_nettype none
`include "spbs_map.svh"

module tb;
  import spbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  int seed = 41;
  localparam logic hi = 1'b1;
  localparam logic lo = 1'b0;
  spbs_addr_t addr, a, base;
  logic proc_n, ctrl_n, adv_n, sel_a_n, sel_b, sel_c_n, gw_n, bwe_n;
  logic oe_n, sleep, doe, poe;
  spbs_lane_t bsel_n;
  spbs_word_t wire_word, w;
  logic [`SPBS_DATA_W-1:0] dout;
  logic [`SPBS_PAR_W-1:0] pout;
  spbs_word_t mem [spbs_addr_t];

  always #4 clk = ~clk;

  spbs_top spbs_top_i (
    .CLOCK(clk), .RST(rst), .ADDR(addr), .PROC_ADDR_STROBE_N(proc_n),
    .CTRL_ADDR_STROBE_N(ctrl_n), .BURST_ADVANCE_N(adv_n),
    .CHIP_SEL_A_N(sel_a_n), .CHIP_SEL_B(sel_b), .CHIP_SEL_C_N(sel_c_n),
    .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_EN_N(bwe_n), .BYTE_SEL_N(bsel_n),
    .BURST_MODE_SEL(mode), .SLEEP_REQ(sleep), .OUT_EN_N(oe_n),
    .DATA_IN(wire_word[15:0]), .DATA_OUT(dout), .DATA_OE(doe),
    .PARITY_IN(wire_word[17:16]), .PARITY_OUT(pout), .PARITY_OE(poe));

  spbs_host spbs_host_i (
    .clk(clk), .dev_word({pout, dout}), .dev_oe(doe), .addr(addr),
    .proc_n(proc_n), .ctrl_n(ctrl_n), .adv_n(adv_n), .sel_a_n(sel_a_n),
    .sel_b(sel_b), .sel_c_n(sel_c_n), .gw_n(gw_n), .bwe_n(bwe_n),
    .bsel_n(bsel_n), .oe_n(oe_n), .sleep(sleep), .wire_word(wire_word));

  // ==========================================
  // Expectations and checks
  function automatic spbs_addr_t baddr(spbs_addr_t ad, spbs_step_t s);
    baddr = ad;
    baddr[1:0] = mode ? ad[1:0] ^ s : ad[1:0] + s;
  endfunction : baddr

  function automatic spbs_word_t merge(spbs_word_t o, spbs_word_t n,
                                       logic g, logic b, spbs_lane_t bs);
    merge = o;
    for (int i = 0; i < 2; i++) begin
      if (!g || (!b && !bs[i])) begin
        merge[8*i +: 8] = n[8*i +: 8];
        merge[16+i] = n[16+i];
      end
    end
  endfunction : merge

  task automatic chk(input string nm, input spbs_word_t seen,
                     input spbs_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic oechk(input logic e);
    chk("output enables", {16'h0, poe, doe}, {16'h0, e, e});
  endtask : oechk

  task automatic idle();
    spbs_host_i.cyc(hi, hi, hi, hi, hi, hi, 2'h3, '0, '0);
  endtask : idle

  task automatic desel();
    spbs_host_i.cyc(hi, lo, lo, hi, hi, hi, 2'h3, '0, '0);
  endtask : desel

  task automatic cwr(input spbs_addr_t ad, input logic g, b,
                     input spbs_lane_t bs);
    w = 18'($random(seed));
    spbs_host_i.cyc(hi, lo, hi, 1'($random(seed)), g, b, bs, ad, w);
    mem[ad] = merge(mem.exists(ad) ? mem[ad] : '0, w, g, b, bs);
  endtask : cwr

  task automatic rd(input spbs_addr_t ad);
    spbs_host_i.cyc(hi, lo, hi, hi, hi, hi, 2'h3, ad, '0);
    idle();
    idle();
    chk("read word", {pout, dout}, mem[ad]);
    oechk(1'b1);
  endtask : rd

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // ==========================================
  // Scenarios, once per burst order
  initial begin
    for (int m = 0; m < 2; m++) begin
      rst = 1'b1;
      mode = m[0];
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      base = 18'($random(seed)) & 18'h3fffc;
      for (int k = 0; k < 4; k++) begin
        cwr(base + 18'(k), 1'b0, 1'($random(seed)), 2'($random(seed)));
      end
      for (int k = 0; k < 8; k++) begin
        cwr(base + 18'(k % 4), 1'(k != 3), 1'($random(seed)),
            2'($random(seed)));
      end
      a = base + 18'($random(seed) & 3);
      w = 18'($random(seed));
      spbs_host_i.cyc(lo, hi, hi, lo, lo, lo, 2'h0, a, ~w);
      spbs_host_i.cyc(hi, hi, hi, hi, lo, hi, 2'h3, base, w);
      mem[a] = w;
      oechk(1'b0);
      spbs_host_i.cyc(lo, lo, hi, hi, lo, lo, 2'h0, a ^ 18'h1, ~w);
      idle();
      chk("proc start read", {pout, dout}, mem[a ^ 18'h1]);
      desel();
      a = base + 18'($random(seed) & 3);
      spbs_host_i.cyc(hi, lo, hi, hi, hi, hi, 2'h3, a, '0);
      oechk(1'b0);
      for (int k = 1; k < 6; k++) begin
        spbs_host_i.cyc(hi, hi, hi, 1'(k > 3), hi, hi, 2'h3, a,
                        '0);
        chk("burst word", {pout, dout},
            mem[baddr(a, 2'(k > 4 ? 3 : k - 1))]);
        oechk(1'b1);
      end
      spbs_host_i.pins(1'b1, 1'b0);
      #1 oechk(1'b0);
      spbs_host_i.pins(1'b0, 1'b0);
      #1 oechk(1'b1);
      a = baddr(a, 2'h3);
      w = 18'($random(seed));
      spbs_host_i.cyc(hi, hi, hi, hi, lo, hi, 2'h3, base, w);
      mem[a] = w;
      // Output enable low after the write: only the write safeguard masks
      spbs_host_i.pins(1'b0, 1'b0);
      #1 oechk(1'b0);
      rd(a);
      desel();
      oechk(1'b0);
      spbs_host_i.pins(1'b0, 1'b1);
      repeat (2) idle();
      // Write attempt while asleep must leave the word intact
      w = ~mem[a];
      spbs_host_i.cyc(hi, lo, hi, hi, lo, hi, 2'h3, a, w);
      idle();
      oechk(1'b0);
      spbs_host_i.pins(1'b0, 1'b0);
      repeat (3) idle();
      rd(a);
    end
    end_sim();
  end

  // Watchdog, far beyond the some 80 cycles needed
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
